// ===== rtl/esd_params.svh
`ifndef ESD_PARAMS_SVH
`define ESD_PARAMS_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define ESD_REG_DETAIL      4'h0
`define ESD_REG_CATEGORY    4'h1
`define ESD_REG_CONFIG      4'h2
// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define ESD_CV_BIT          24
`define ESD_PREDICATE_CODE_HI         23
`define ESD_PREDICATE_CODE_LO         20
`define ESD_RN_HI           9
`define ESD_RN_LO           5
`define ESD_RV_BIT          2
`define ESD_PREDICATE_CODE_ALWAYS     4'hE
`define ESD_DESC_PC         4'hF
`define ESD_REG_ZR          5'h1F
`define ESD_CAT_UNKNOWN     6'h00
`define ESD_CAT_WAIT        6'h01
`define ESD_CAT_FP_ACCESS   6'h07
`define ESD_KIND_WFI        2'h0
`define ESD_KIND_WFE        2'h1
`define ESD_KIND_TIMED_WAIT_INTERRUPT_INSN       2'h2
`define ESD_KIND_TIMED_WAIT_EVENT_INSN       2'h3
`endif

// ===== rtl/esd_pkg.sv
package esd_pkg;
  typedef struct packed {
    logic       valid;
    logic       from_64;
    logic       mixed_len;
    logic       conditional;
    logic [3:0] predicate_code;
    logic       unpredictable;
    logic       timed_wait;
    logic       is_event;
    logic [3:0] reg_desc;
    logic [1:0] el;
  } esd_wait_t;

  typedef struct packed {
    logic unalloc;
    logic debug_inacc;
    logic short_vec_fp;
    logic fp_absent;
    logic hvc_disabled;
    logic smc_disabled;
    logic hlt_disabled;
    logic ctl_bit_fault;
    logic sp0_sel0;
    logic el12_no_e2h;
    logic dcps_fault;
    logic sdd_trap_el3;
    logic srs_mon;
    logic banked_mon;
    logic transaction_commit_insn_nontx;
    logic tge_fp;
  } esd_cause_t;

  typedef struct packed {
    logic level1_wait_event_untrap;
    logic level1_wait_int_untrap;
    logic trap_wait_event_bit_l2;
    logic trap_wait_int_bit_l2;
    logic trap_wait_event_bit_l3;
    logic trap_wait_int_bit_l3;
    logic general_trap_bit;
    logic l2_enabled;
    logic l3_present;
    logic secure_debug_disable;
    logic debug_state;
  } esd_ctl_t;

  typedef enum logic [1:0] {ESD_IDLE, ESD_TRAP_WAIT, ESD_TRAP_UNK} esd_state_t;
endpackage

// ===== rtl/esd_detail.sv
// Overview of operation
// - Report register numbers in 64-bit numbering
// - Predictable descriptor 15 reports 0b11111
// - Unpredictable descriptor 15 may report 0b11111
// - Unknown-reason detail field is all zero
// - Unknown-reason sets instruction length flag
// - Uncovered exceptions use unknown-reason class
// - Inaccessible, short-vector, absent-FP go unknown-reason
// - Disabled calls, halts, control-bit faults: unknown-reason
// - Stack pointer and alias misuse: unknown-reason
// - Debug change-level faults: unknown-reason
// - Secure-debug-disabled level-3 traps: unknown-reason
// - Monitor stack, banked, commit cases: unknown-reason
// - General-trap rerouted class 7: unknown-reason
// - Predicate valid flag at bit 24
// - Predicate code 0b1110 from 64-bit state
// - Fixed-length: instruction condition or 0b1110
// - Mixed-length: flag choice with condition
// - Bits 9:5 carry timed-wait register
// - Register-valid flag set on timed waits
// - Kind field encodes the wait instruction
// - Kind upper bit zero without timed waits
// - Wait traps follow untrap and trap bits
// - Fields need no forced reset value
//
// The implementer's own choices: strobed register access and the register offsets.
`include "esd_params.svh"
`timescale 1ns/1ps
`default_nettype none
module esd_detail #(
  parameter bit TIMED_WAIT = 1'b1,
  parameter bit MIXED_CV   = 1'b1
) (
  input  wire logic                  clock_in,
  input  wire logic                  rst_in,
  input  wire esd_pkg::esd_wait_t    wait_in,
  input  wire esd_pkg::esd_cause_t   cause_in,
  input  wire logic [1:0]            cur_el_in,
  input  wire logic [3:0]            addr_in,
  input  wire logic [31:0]           wdata_in,
  input  wire logic                  wr_in,
  input  wire logic                  rd_in,
  output logic [31:0]                rdata_out,
  output logic                       wait_trap_out,
  output logic                       unk_trap_out,
  output logic [24:0]                detail_out,
  output logic [5:0]                 category_out,
  output logic                       size_flag_out
);
  // ----------------------------------------
  // Register number mapping
  // ----------------------------------------
  // Descriptor 15 has no 64-bit equivalent; zero-register code is always legal
  function automatic logic [4:0] map_reg(input logic [3:0] d);
    map_reg = (d == `ESD_DESC_PC) ? `ESD_REG_ZR : {1'b0, d};
  endfunction

  esd_pkg::esd_ctl_t ctl_q;
  esd_pkg::esd_state_t state_q;
  logic [24:0] detail_q;
  logic [5:0]  cat_q;
  logic        il_q;

  // ----------------------------------------
  // Trap decisions
  // ----------------------------------------
  wire el0 = (cur_el_in == 2'h0);
  wire el_low = (cur_el_in != 2'h3);
  wire l1_trap = el0 & (wait_in.is_event ? ~ctl_q.level1_wait_event_untrap
                                         : ~ctl_q.level1_wait_int_untrap);
  wire l2_trap = (cur_el_in < 2'h2) & ctl_q.l2_enabled &
                 (wait_in.is_event ? ctl_q.trap_wait_event_bit_l2
                                   : ctl_q.trap_wait_int_bit_l2);
  wire l3_trap = el_low & ctl_q.l3_present &
                 (wait_in.is_event ? ctl_q.trap_wait_event_bit_l3
                                   : ctl_q.trap_wait_int_bit_l3);
  // Debug with secure debug off turns level-3 traps into unknown-reason
  wire l3_unk = l3_trap & ctl_q.debug_state & ctl_q.secure_debug_disable;
  // Lower-level trap still wins when the level-3 route turns unknown-reason
  wire wait_take = wait_in.valid & (l1_trap | l2_trap | (l3_trap & ~l3_unk));
  wire any_cause = |cause_in;
  wire unk_take = any_cause | (wait_in.valid & l3_unk & ~l1_trap & ~l2_trap);

  // ----------------------------------------
  // Wait encoding
  // ----------------------------------------
  wire [1:0] kind = {TIMED_WAIT & wait_in.timed_wait, wait_in.is_event};
  wire cv = wait_in.from_64 | ~wait_in.mixed_len | MIXED_CV;
  wire [3:0] predicate_code = (wait_in.from_64 | ~wait_in.conditional) ? `ESD_PREDICATE_CODE_ALWAYS
                    : wait_in.predicate_code;
  wire timed = TIMED_WAIT & wait_in.timed_wait;
  wire [4:0] rn = timed ? map_reg(wait_in.reg_desc) : 5'h00;
  wire [24:0] wait_detail = {cv, (cv ? predicate_code : 4'h0), 10'h000, rn, 2'h0,
                             timed, kind};

  // ----------------------------------------
  // Register bus decode
  // ----------------------------------------
  wire wr_cfg = wr_in & (addr_in == `ESD_REG_CONFIG);
  wire wr_det = wr_in & (addr_in == `ESD_REG_DETAIL);
  wire wr_cat = wr_in & (addr_in == `ESD_REG_CATEGORY);

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ctl_q <= '0;
    end else if (wr_cfg) begin
      ctl_q <= esd_pkg::esd_ctl_t'(wdata_in[10:0]);
    end
  end

  // Capture path: exception entry beats a software write in the same cycle
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= esd_pkg::ESD_IDLE;
    end else if (unk_take) begin
      state_q <= esd_pkg::ESD_TRAP_UNK;
    end else if (wait_take) begin
      state_q <= esd_pkg::ESD_TRAP_WAIT;
    end else begin
      state_q <= esd_pkg::ESD_IDLE;
    end
  end

  // No reset on syndrome storage; content is unknown after reset
  always_ff @(posedge clock_in) begin
    if (unk_take) begin
      detail_q <= 25'h0000000;
      cat_q    <= `ESD_CAT_UNKNOWN;
      il_q     <= 1'b1;
    end else if (wait_take) begin
      detail_q <= wait_detail;
      cat_q    <= `ESD_CAT_WAIT;
      il_q     <= 1'b1;
    end else begin
      if (wr_det) begin
        detail_q <= wdata_in[24:0];
      end
      if (wr_cat) begin
        cat_q <= wdata_in[5:0];
        il_q  <= wdata_in[6];
      end
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 32'h00000000;
    end else if (rd_in) begin
      case (addr_in)
        `ESD_REG_DETAIL:   rdata_out <= {7'h00, detail_q};
        `ESD_REG_CATEGORY: rdata_out <= {25'h0000000, il_q, cat_q};
        `ESD_REG_CONFIG:   rdata_out <= {21'h000000, ctl_q};
        default:           rdata_out <= 32'h00000000;
      endcase
    end else begin
      rdata_out <= 32'h00000000;
    end
  end

  assign wait_trap_out = (state_q == esd_pkg::ESD_TRAP_WAIT);
  assign unk_trap_out  = (state_q == esd_pkg::ESD_TRAP_UNK);
  assign detail_out    = detail_q;
  assign category_out  = cat_q;
  assign size_flag_out = il_q;
endmodule
`default_nettype wire

// ===== sim/esd_detail_properties.sv
`timescale 1ns/1ps
`default_nettype none
module esd_detail_properties (
  input wire logic                clock_in,
  input wire logic                rst_in,
  input wire esd_pkg::esd_wait_t  wait_in,
  input wire esd_pkg::esd_cause_t cause_in,
  input wire logic                wait_trap_out,
  input wire logic                unk_trap_out,
  input wire logic [24:0]         detail_out,
  input wire logic [5:0]          category_out,
  input wire logic                size_flag_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // ----------------------------------------
  // Syndrome checks
  // ----------------------------------------
  chk_unk_zero: assert property (unk_trap_out |-> detail_out == 25'h0)
    else $error("unknown trap detail not zero");
  chk_unk_size: assert property (unk_trap_out |-> size_flag_out && category_out == 6'h00)
    else $error("unknown trap class or size wrong");
  // Unknown-reason must win over a wait trap in the same cycle
  chk_cause_unk: assert property (|cause_in |=> unk_trap_out && !wait_trap_out)
    else $error("cause did not give unknown trap");
  chk_wait_rsvd: assert property (wait_trap_out |-> detail_out[19:10] == 10'h0 &&
                                  detail_out[4:3] == 2'h0)
    else $error("wait reserved bits set");
  chk_rv_timed: assert property (wait_trap_out |-> detail_out[2] == detail_out[1])
    else $error("register valid flag wrong");
  chk_wait_wide: assert property (wait_in.valid && wait_in.from_64 ##1 wait_trap_out |->
                                  detail_out[24:20] == 5'h1E)
    else $error("wide state predicate wrong");
  chk_wait_narrow: assert property (wait_in.valid && !wait_in.from_64 ##1 wait_trap_out |->
    detail_out[24:20] == {1'h1, $past(wait_in.conditional) ? $past(wait_in.predicate_code) : 4'hE})
    else $error("narrow state predicate wrong");
  chk_kind_code: assert property (wait_in.valid ##1 wait_trap_out |->
    detail_out[1:0] == {$past(wait_in.timed_wait), $past(wait_in.is_event)})
    else $error("trapped kind wrong");
  chk_timed_reg: assert property (wait_in.valid && wait_in.timed_wait ##1 wait_trap_out |->
    detail_out[9:5] == ($past(wait_in.reg_desc) == 4'hF ? 5'h1F : {1'h0, $past(wait_in.reg_desc)}))
    else $error("timed wait register wrong");
  cov_unk: cover property (unk_trap_out);
  cov_timed: cover property (wait_trap_out && detail_out[1]);
  cov_narrow: cover property (wait_trap_out && detail_out[23:20] != 4'hE);
endmodule
bind esd_detail esd_detail_properties u_props (.clock_in(clock_in), .rst_in(rst_in),
  .wait_in(wait_in), .cause_in(cause_in), .wait_trap_out(wait_trap_out),
  .unk_trap_out(unk_trap_out), .detail_out(detail_out), .category_out(category_out),
  .size_flag_out(size_flag_out));
`default_nettype wire

// ===== sim/test_exception_syndrome_detail.sv
`timescale 1ns/1ps
`default_nettype none
module test_exception_syndrome_detail;
  logic                clock_in = 1'h0;
  logic                rst_in = 1'h1;
  logic                wr_in = 1'h0;
  logic                rd_in = 1'h0;
  logic [1:0]          cur_el_in = 2'h1;
  logic [3:0]          addr_in = 4'h0;
  logic [31:0]         wdata_in = 32'h0;
  esd_pkg::esd_wait_t  wait_in = '0;
  esd_pkg::esd_cause_t cause_in = '0;
  logic [31:0]         rdata_out;
  logic                wt, ut, sz;
  logic [24:0]         det;
  logic [5:0]          cat;
  int                  miscompares = 0;
  int                  n_tests = 0;
  esd_detail dut (.clock_in(clock_in), .rst_in(rst_in), .wait_in(wait_in), .cause_in(cause_in),
    .cur_el_in(cur_el_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .wait_trap_out(wt), .unk_trap_out(ut), .detail_out(det),
    .category_out(cat), .size_flag_out(sz));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  initial begin
    forever #2.5 clock_in = ~clock_in;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up;
    if (miscompares == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'h1;
    @(posedge clock_in);
    wr_in <= 1'h0;
    @(posedge clock_in);
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    addr_in <= a;
    rd_in   <= 1'h1;
    @(posedge clock_in);
    rd_in <= 1'h0;
    #1;
    chk(nm, e, rdata_out);
    @(posedge clock_in);
  endtask
  // Gap cycle after each attempt keeps drivers to one change per step
  task automatic wf(input logic f64, input logic [3:0] cd, input logic [1:0] k,
                    input logic [3:0] rd, input logic tr);
    logic [24:0] e;
    e = {1'h1, f64 ? 4'hE : cd, 10'h0, !k[1] ? 5'h00 : rd == 4'hF ? 5'h1F : {1'h0, rd},
         2'h0, k[1], k};
    wait_in <= {1'h1, f64, 1'h0, cd != 4'hE, cd, 1'h0, k, rd, 2'h1};
    @(posedge clock_in);
    wait_in <= '0;
    #1;
    chk("wait_trap", {31'h0, tr}, {31'h0, wt});
    if (tr) begin
      chk("detail", {7'h0, e}, {7'h0, det});
    end
    @(posedge clock_in);
  endtask
  task automatic dbg_unk;
    wait_in <= {1'h1, 1'h1, 1'h0, 1'h0, 4'hE, 1'h0, 2'h1, 4'h0, 2'h1};
    @(posedge clock_in);
    wait_in <= '0;
    #1;
    chk("dbg_unk_trap", 32'h2, {30'h0, ut, wt});
    chk("dbg_unk_detail", 32'h0, {7'h0, det});
    @(posedge clock_in);
  endtask
  task automatic unk_all;
    for (int i = 0; i < 16; i++) begin
      cause_in <= 16'h1 << i;
      wait_in  <= 17'h19C01;
      @(posedge clock_in);
      cause_in <= '0;
      wait_in  <= '0;
      #1;
      chk("unk_trap", 32'h2, {30'h0, ut, wt});
      chk("unk_detail", 32'h0, {7'h0, det});
      chk("unk_class", 32'h40, {25'h0, sz, cat});
      @(posedge clock_in);
    end
  endtask
  initial begin
    repeat (16) @(posedge clock_in);
    rst_in <= 1'h0;
    @(posedge clock_in);
    reg_wr(4'h2, 32'h188);
    reg_rd(4'h2, 32'h188, "config");
    reg_rd(4'h7, 32'h0, "unmapped");
    wf(1'h1, 4'hE, 2'h0, 4'h0, 1'h1);
    wf(1'h1, 4'hE, 2'h1, 4'h0, 1'h1);
    wf(1'h1, 4'hE, 2'h2, 4'hF, 1'h1);
    wf(1'h1, 4'hE, 2'h3, 4'h7, 1'h1);
    wf(1'h0, 4'h3, 2'h3, 4'hF, 1'h1);
    wf(1'h0, 4'hE, 2'h0, 4'h0, 1'h1);
    unk_all();
    reg_wr(4'h2, 32'h600);
    wf(1'h1, 4'hE, 2'h0, 4'h0, 1'h0);
    cur_el_in <= 2'h0;
    reg_wr(4'h2, 32'h0);
    wf(1'h1, 4'hE, 2'h1, 4'h0, 1'h1);
    reg_wr(4'h2, 32'h47);
    wf(1'h1, 4'hE, 2'h1, 4'h0, 1'h1);
    reg_wr(4'h2, 32'h647);
    dbg_unk();
    reg_wr(4'h0, 32'h1ABCDEF);
    reg_rd(4'h0, 32'h1ABCDEF, "detail_reg");
    reg_wr(4'h1, 32'h45);
    reg_rd(4'h1, 32'h45, "category_reg");
    wrap_up();
  end
endmodule
`default_nettype wire
